// *** src/pwg_pkg.sv ***
// Shared constants and types of the parallel word pattern generator
package pwg_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int APB_ADDR_W = 8;
   localparam int APB_DATA_W = 32;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_CTRL      = 6'h00;
   localparam logic [5:0] IDX_START     = 6'h06;
   localparam logic [5:0] IDX_LAST      = 6'h08;
   localparam logic [5:0] IDX_LAYOUT    = 6'h0C;
   localparam logic [5:0] IDX_DIV_HI    = 6'h0E;
   localparam logic [5:0] IDX_DIV_LO    = 6'h10;
   localparam logic [5:0] IDX_LOAD_PTR  = 6'h18;
   localparam logic [5:0] IDX_LOAD_PORT = 6'h1A;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_WG_BIT      = 0;
   localparam int CTRL_SINGLE_BIT  = 1;
   localparam int CTRL_RUN_BIT     = 4;
   localparam int CTRL_BUSY_BIT    = 15;
   localparam int LAYOUT_OWC_LSB   = 4;
   localparam int LAYOUT_WS_LSB    = 0;

   // ----------------------------------------------------------------
   // Values after reset and well known values
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RST         = 16'h0000;
   localparam logic [15:0] PTR_RST          = 16'h0000;
   localparam logic [15:0] LAYOUT_RST       = 16'h0000;
   localparam logic [15:0] DIV_RST          = 16'h0000;
   localparam logic [15:0] CTRL_START_VALUE = 16'h0011;

   // ----------------------------------------------------------------
   // Pattern memory and channels
   // ----------------------------------------------------------------
   localparam int MEM_WORDS = 32768;
   localparam int MEM_IDX_W = 15;
   localparam int CHANNELS  = 16;

   // ----------------------------------------------------------------
   // Word clock base tick
   // ----------------------------------------------------------------
   localparam int         CLK_PERIOD_NS  = 4;
   localparam int         BASE_TICK_NS   = 50;
   localparam int         BASE_TICK_CYC  = BASE_TICK_NS / CLK_PERIOD_NS;
   localparam logic [3:0] BASE_TICK_LAST = 4'(BASE_TICK_CYC - 1);

   // Engine states
   typedef enum logic {ST_IDLE, ST_RUN} pwg_state_t;

endpackage : pwg_pkg

// *** src/pwg_pattern_mem.sv ***
// Pattern memory: tristate half and data half of each memory word
`timescale 1ns/10ps
module pwg_pattern_mem (
   // Clock
   input  wire  logic                           pclk,
   input  wire  logic                           ce,
   // Host write port, half-word address
   input  wire  logic                           wr_en,
   input  wire  logic [15:0]                    wr_addr,
   input  wire  logic [15:0]                    wr_data,
   // Host read port, half-word address
   input  wire  logic [15:0]                    host_addr,
   output logic       [15:0]                    host_rdata,
   // Engine read port, memory word index
   input  wire  logic [pwg_pkg::MEM_IDX_W-1:0]  rd_idx,
   output logic       [15:0]                    rd_ts,
   output logic       [15:0]                    rd_data
);
   import pwg_pkg::*;

   logic [15:0] ts_mem   [0:MEM_WORDS-1];
   logic [15:0] data_mem [0:MEM_WORDS-1];

   // Even half-address goes to tristate half, odd to data half
   always_ff @(posedge pclk) begin
      if (ce && wr_en) begin
         if (wr_addr[0]) begin
            data_mem[wr_addr[15:1]] <= wr_data;   // [R6]
         end else begin
            ts_mem[wr_addr[15:1]] <= wr_data;     // [R6]
         end
      end
   end

   // Synchronous reads, one cycle latency
   always_ff @(posedge pclk) begin
      if (ce) begin
         rd_ts      <= ts_mem[rd_idx];
         rd_data    <= data_mem[rd_idx];
         host_rdata <= host_addr[0] ? data_mem[host_addr[15:1]] : ts_mem[host_addr[15:1]];
      end
   end

   chk_pair_write: assert property (@(posedge pclk) ce && wr_en && wr_addr[0] |=>
      data_mem[$past(wr_addr[15:1])] == $past(wr_data))  // [R6]
      else $error("data half not stored at odd address");

endmodule : pwg_pattern_mem

// *** src/pwg_pattern_generator.sv ***
// Parallel word pattern generator: APB registers and output engine
//
// What this block does
// R1 - Data word loads a shift register shifted right, field LSB first.
// R2 - One-bit words: all 16 data bits go out in turn on channel 1.
// R3 - Two-bit words: low byte on channel 1, high byte on channel 9.
// R4 - Four-bit words: nibbles go to channels 1, 5, 9 and 13.
// R5 - Tristate bits at zero keep their channels driven.
// R6 - Even address holds tristate half, odd address holds data half.
// R7 - Last word count field is sixteen minus words used in final word.
// R8 - Unused bit positions of a partial final memory word are ignored.
// R9 - Software sets load pointer to start index plus one before running.
// R10 - Control value 0011 hex starts continuous software run.
// R11 - Each load port write stores at pointer then advances pointer.
// R12 - Run covers start index through last index inclusive.
// R13 - Tristate bit at one forces its channel to high impedance.
// R14 - Word width 1, 2, 4, 8 or 16 bits, tristate applied alike.
`timescale 1ns/10ps
module pwg_pattern_generator (
   // Clock, reset and clock enable
   input  wire  logic                            pclk,
   input  wire  logic                            presetn,
   input  wire  logic                            ce,
   // APB slave
   input  wire  logic                            psel,
   input  wire  logic                            penable,
   input  wire  logic                            pwrite,
   input  wire  logic [pwg_pkg::APB_ADDR_W-1:0]  paddr,
   input  wire  logic [pwg_pkg::APB_DATA_W-1:0]  pwdata,
   output logic       [pwg_pkg::APB_DATA_W-1:0]  prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   // Output channels
   output logic       [pwg_pkg::CHANNELS-1:0]    chan_out,
   output logic       [pwg_pkg::CHANNELS-1:0]    chan_oe
);
   import pwg_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0]          ctrl_q;
   logic [15:0]          start_q;
   logic [15:0]          last_q;
   logic [15:0]          layout_q;
   logic [15:0]          div_hi_q;
   logic [15:0]          div_lo_q;
   logic [15:0]          load_ptr_q;
   logic [31:0]          prdata_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic [15:0]          chan_out_q;
   logic [15:0]          chan_oe_q;
   pwg_state_t           state_q;
   logic [3:0]           pre_q;
   logic [31:0]          div_cnt_q;
   logic [15:0]          sr_data_q;
   logic [15:0]          sr_ts_q;
   logic [4:0]           left_q;
   logic [MEM_IDX_W-1:0] nxt_q;
   logic                 last_loaded_q;
   logic [5:0]           idx;
   logic                 hit;
   logic                 acc;
   logic                 wr_fire;
   logic [15:0]          rd_mux;
   logic [15:0]          host_rdata;
   logic [15:0]          rd_ts;
   logic [15:0]          rd_data;
   logic                 go;
   logic                 tick;
   logic                 need_load;
   logic                 stop;
   logic [2:0]           ws_k;
   logic [4:0]           words_per_mem;
   logic [3:0]           field_m1;
   logic [4:0]           last_raw;
   logic [4:0]           last_cnt;
   logic [4:0]           load_cnt;
   logic [15:0]          chan_mask;
   logic [15:0]          pres_data;
   logic [15:0]          pres_ts;
   logic                 at_last;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------

   // First access cycle takes the request, completion edge commits it
   assign idx     = paddr[7:2];
   assign acc     = psel & penable & ~pready_q;
   assign wr_fire = psel & penable & pready_q & pwrite & hit;

   // Address decode and read mux
   always_comb begin
      hit    = 1'b1;
      rd_mux = 16'h0000;
      case (idx)
         IDX_CTRL: begin
            rd_mux = {state_q == ST_RUN, ctrl_q[14:0]};
         end
         IDX_START:     rd_mux = start_q;
         IDX_LAST:      rd_mux = last_q;
         IDX_LAYOUT:    rd_mux = layout_q;
         IDX_DIV_HI:    rd_mux = div_hi_q;
         IDX_DIV_LO:    rd_mux = div_lo_q;
         IDX_LOAD_PTR:  rd_mux = load_ptr_q;
         IDX_LOAD_PORT: rd_mux = host_rdata;
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // One wait state, then answer with data or error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (ce) begin
         pready_q  <= acc;
         pslverr_q <= acc & ~hit;
         if (acc) begin
            prdata_q <= (hit && !pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------

   // Pointers, layout and word clock divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q  <= PTR_RST;
         last_q   <= PTR_RST;
         layout_q <= LAYOUT_RST;
         div_hi_q <= DIV_RST;
         div_lo_q <= DIV_RST;
      end else if (ce && wr_fire) begin
         case (idx)
            IDX_START:  start_q  <= pwdata[15:0];
            IDX_LAST:   last_q   <= pwdata[15:0];
            IDX_LAYOUT: layout_q <= pwdata[15:0];
            IDX_DIV_HI: div_hi_q <= pwdata[15:0];
            IDX_DIV_LO: div_lo_q <= pwdata[15:0];
            default: begin
            end
         endcase
      end
   end

   // Load pointer: direct write, or advance after each load port write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_ptr_q <= PTR_RST;
      end else if (ce && wr_fire) begin
         if (idx == IDX_LOAD_PTR) begin
            load_ptr_q <= pwdata[15:0];
         end else if (idx == IDX_LOAD_PORT) begin
            load_ptr_q <= load_ptr_q + 16'h0001;  // [R11]
         end
      end
   end

   // Control: software write wins over the end-of-run clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RST;
      end else if (ce) begin
         if (wr_fire && idx == IDX_CTRL) begin
            ctrl_q <= pwdata[15:0];               // [R10]
         end else if (stop) begin
            ctrl_q[CTRL_RUN_BIT] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pattern memory
   // ----------------------------------------------------------------
   pwg_pattern_mem u_mem (
      .pclk       (pclk),
      .ce         (ce),
      .wr_en      (wr_fire && idx == IDX_LOAD_PORT),
      .wr_addr    (load_ptr_q),
      .wr_data    (pwdata[15:0]),
      .host_addr  (load_ptr_q),
      .host_rdata (host_rdata),
      .rd_idx     (nxt_q),
      .rd_ts      (rd_ts),
      .rd_data    (rd_data)
   );

   // ----------------------------------------------------------------
   // Output word geometry
   // ----------------------------------------------------------------

   // Width code is a left-aligned run of ones: 0 1 2 3 4 -> 1 2 4 8 16 bits
   assign ws_k = {2'b00, layout_q[LAYOUT_WS_LSB+3]} + {2'b00, layout_q[LAYOUT_WS_LSB+2]}
               + {2'b00, layout_q[LAYOUT_WS_LSB+1]} + {2'b00, layout_q[LAYOUT_WS_LSB]};
   assign words_per_mem = 5'd16 >> ws_k;         // [R14]
   assign field_m1      = 4'(words_per_mem - 5'd1);

   // Words in final memory word, clipped to what one word holds
   assign last_raw = 5'd16 - {1'b0, layout_q[LAYOUT_OWC_LSB+3:LAYOUT_OWC_LSB]};  // [R7]
   assign last_cnt = (last_raw > words_per_mem) ? words_per_mem : last_raw;
   assign at_last  = (nxt_q == last_q[MEM_IDX_W-1:0]);
   assign load_cnt = at_last ? last_cnt : words_per_mem;  // [R8]

   // Channel used when it starts a field of the data word
   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_mask
         localparam logic [3:0] CH = 4'(gi);
         assign chan_mask[gi] = ((CH & field_m1) == 4'h0);  // [R2] [R3] [R4]
      end
   endgenerate

   // ----------------------------------------------------------------
   // Word clock
   // ----------------------------------------------------------------

   // Base tick prescaler, then programmable divider
   assign tick = (state_q == ST_RUN) && (pre_q == BASE_TICK_LAST)
                 && (div_cnt_q == {div_hi_q, div_lo_q});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q     <= 4'h0;
         div_cnt_q <= 32'h0000_0000;
      end else if (ce) begin
         if (state_q != ST_RUN) begin
            pre_q     <= 4'h0;
            div_cnt_q <= 32'h0000_0000;
         end else if (pre_q == BASE_TICK_LAST) begin
            pre_q     <= 4'h0;
            div_cnt_q <= tick ? 32'h0000_0000 : div_cnt_q + 32'h0000_0001;
         end else begin
            pre_q <= pre_q + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Output engine
   // ----------------------------------------------------------------

   // Run request and per-tick decisions
   assign go        = ctrl_q[CTRL_WG_BIT] & ctrl_q[CTRL_RUN_BIT];  // [R10]
   assign need_load = (left_q <= 5'd1);
   assign stop      = tick & need_load & last_loaded_q & ctrl_q[CTRL_SINGLE_BIT];

   // Word presented next: fresh memory word, or current shifted right
   assign pres_data = need_load ? rd_data : (sr_data_q >> 1);  // [R1]
   assign pres_ts   = need_load ? rd_ts   : (sr_ts_q >> 1);    // [R14]

   // Run state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else if (ce) begin
         case (state_q)
            ST_IDLE: begin
               if (go) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!go || stop) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Fetch pointer and words left in the shift register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nxt_q         <= '0;
         left_q        <= 5'd0;
         last_loaded_q <= 1'b0;
      end else if (ce) begin
         if (state_q == ST_IDLE) begin
            nxt_q         <= start_q[MEM_IDX_W-1:0];
            left_q        <= 5'd0;
            last_loaded_q <= 1'b0;
         end else if (tick && !stop) begin
            if (need_load) begin
               left_q        <= load_cnt;           // [R7] [R8]
               last_loaded_q <= at_last;
               nxt_q         <= at_last ? start_q[MEM_IDX_W-1:0]
                                        : nxt_q + 15'd1;  // [R12]
            end else begin
               left_q <= left_q - 5'd1;
            end
         end
      end
   end

   // Shift registers hold the word now on the channels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_data_q <= 16'h0000;
         sr_ts_q   <= 16'h0000;
      end else if (ce && tick && !stop) begin
         sr_data_q <= pres_data;                  // [R1]
         sr_ts_q   <= pres_ts;
      end
   end

   // Channel pins: drive used channels unless tristate bit is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_out_q <= 16'h0000;
         chan_oe_q  <= 16'h0000;
      end else if (ce) begin
         if (state_q != ST_RUN || stop) begin
            chan_out_q <= 16'h0000;
            chan_oe_q  <= 16'h0000;
         end else if (tick) begin
            chan_out_q <= pres_data & chan_mask;
            chan_oe_q  <= chan_mask & ~pres_ts;   // [R5] [R13]
         end
      end
   end

   // Outputs straight from flip-flops
   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign chan_out = chan_out_q;
   assign chan_oe  = chan_oe_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_load_advance: assert property (ce && wr_fire && idx == IDX_LOAD_PORT |=>  // [R11]
      load_ptr_q == $past(load_ptr_q) + 16'h0001)
      else $error("load pointer did not advance");

   chk_shift_right: assert property (ce && tick && !need_load && !stop |=>  // [R1]
      sr_data_q == ($past(sr_data_q) >> 1))
      else $error("data word not shifted right");

   chk_one_bit_chan: assert property (ce && tick && ws_k == 3'd0 |=>  // [R2]
      (chan_oe_q & 16'hFFFE) == 16'h0000 && chan_out_q[15:1] == 15'h0000)
      else $error("one-bit words left channel 1");

   chk_two_bit_chan: assert property (ce && tick && ws_k == 3'd1 |=>  // [R3]
      (chan_oe_q & 16'hFEFE) == 16'h0000)
      else $error("two-bit words used wrong channels");

   chk_four_bit_chan: assert property (ce && tick && ws_k == 3'd2 |=>  // [R4]
      (chan_oe_q & 16'hEEEE) == 16'h0000)
      else $error("four-bit words used wrong channels");

   chk_ts_zero_drive: assert property (ce && tick && need_load && !stop
      && rd_ts == 16'h0000 |=> chan_oe_q == $past(chan_mask))  // [R5]
      else $error("cleared tristate bits left channel undriven");

   chk_ts_high_z: assert property ((chan_oe_q & sr_ts_q) == 16'h0000)  // [R13]
      else $error("channel driven with tristate bit set");

   chk_width_mask: assert property (ce && tick |=>  // [R14]
      (chan_oe_q & ~$past(chan_mask)) == 16'h0000)
      else $error("unused channel driven");

   chk_last_count: assert property (ce && tick && need_load && !stop && at_last |=>  // [R7]
      left_q == $past(last_cnt) && left_q <= $past(words_per_mem))
      else $error("final word count wrong");

   chk_wrap_start: assert property (ce && tick && need_load && !stop && at_last |=>  // [R12]
      nxt_q == $past(start_q[MEM_IDX_W-1:0]))
      else $error("run did not wrap to start index");

   chk_start_ctrl: assert property (ce && wr_fire && idx == IDX_CTRL
      && pwdata[15:0] == CTRL_START_VALUE && state_q == ST_IDLE
      |-> ##[1:4] (state_q == ST_RUN))  // [R10]
      else $error("start value did not start a run");

endmodule : pwg_pattern_generator

// *** verification/pwg_target_model.sv ***
// Target system model: channel levels as seen at the far end of the pins
`timescale 1ns/10ps
module pwg_target_model (
   // Clock
   input  wire  logic        pclk,
   // Channel pins from the generator
   input  wire  logic [15:0] chan_out,
   input  wire  logic [15:0] chan_oe,
   // Level seen at the target
   output logic       [15:0] seen
);
   logic [15:0] last_q = 16'h0000;

   // Last level, so released pins can be made to wander
   always_ff @(posedge pclk) begin
      last_q <= seen;
   end

   // Released pins carry no pull, so they toggle every cycle
   always_comb begin
      seen = (chan_out & chan_oe) | (~last_q & ~chan_oe);
   end
endmodule : pwg_target_model

// *** verification/pwg_pattern_generator_test.sv ***
// Self-checking bench of the pattern generator against a reference model
`timescale 1ns/10ps
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
   end \
end
module pwg_pattern_generator_test;
   import pwg_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err;
   logic [15:0] chan_out, chan_oe, seen, used, v;
   logic [31:0] exp_q[$];
   int          ts_m[3], dt_m[3];
   int          bad_count = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          wid[5] = '{1, 2, 4, 8, 16};
   logic [3:0]  code[5] = '{4'h0, 4'h8, 4'hC, 4'hE, 4'hF};
   logic [5:0]  regs[7] = '{IDX_CTRL, IDX_START, IDX_LAST, IDX_LAYOUT,
                            IDX_DIV_HI, IDX_DIV_LO, IDX_LOAD_PTR};

   pwg_pattern_generator dut_u (
      .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .chan_out(chan_out), .chan_oe(chan_oe));

   pwg_target_model target_u (.pclk(pclk), .chan_out(chan_out), .chan_oe(chan_oe),
                              .seen(seen));

   // Clock, 4 ns period
   initial begin
      forever #2 pclk = ~pclk;
   end

   // Hang guard
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         results();
      end
   end

   // One APB transfer; waits for pready, then releases
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) bad_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Read a register and compare
   task automatic rchk(input logic [5:0] idx, input logic [15:0] x);
      apb(1'b0, idx, 16'h0000);
      `CHK({err, rd}, {1'b0, 16'h0000, x})
   endtask : rchk

   // Reset held for 20 cycles
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : do_reset

   // Reference: expected {enables, data} of every output word of one pass
   function automatic void build(input int w, input int last_word_output_count);
      int n, cnt, o, e;
      n = 16 / w;
      exp_q.delete();
      used = 16'h0000;
      for (int f = 0; f < w; f++) begin
         used[f * n] = 1'b1;
      end
      for (int m = 0; m < 3; m++) begin
         cnt = (m == 2 && 16 - last_word_output_count < n) ? 16 - last_word_output_count : n;
         for (int j = 0; j < cnt; j++) begin
            o = 0;
            e = 0;
            for (int f = 0; f < w; f++) begin
               o |= ((dt_m[m] >> (f * n + j)) & 1) << (f * n);
               e |= (((ts_m[m] >> (f * n + j)) & 1) ^ 1) << (f * n);
            end
            exp_q.push_back({16'(e), 16'(o)});
         end
      end
   endfunction : build

   // Compare one output word at the pins and at the target
   task automatic cmp(input logic [31:0] x);
      `CHK(chan_oe & used, x[31:16])
      `CHK(chan_out & (x[31:16] | ~used), x[15:0] & x[31:16])
      `CHK(seen & x[31:16], x[15:0] & x[31:16])
   endtask : cmp

   // Load three memory words, run continuously, check a pass and the wrap
   task automatic run(input int k);
      int n, st, last_word_output_count, i;
      n = 16 / wid[k];
      st = $urandom_range(0, 5);
      last_word_output_count = 16 - $urandom_range(1, n);
      apb(1'b1, IDX_LOAD_PTR, 16'(2 * st));
      for (int m = 0; m < 3; m++) begin
         ts_m[m] = (m == 0 || k == 0) ? 0 : $urandom_range(0, 65535);
         dt_m[m] = $urandom_range(0, 65535);
         apb(1'b1, IDX_LOAD_PORT, 16'(ts_m[m]));
         apb(1'b1, IDX_LOAD_PORT, 16'(dt_m[m]));
      end
      apb(1'b1, IDX_LOAD_PTR, 16'(2 * st + 3));
      rchk(IDX_LOAD_PORT, 16'(dt_m[1]));
      rchk(IDX_LOAD_PTR, 16'(2 * st + 3));
      apb(1'b1, IDX_START, 16'(st));
      apb(1'b1, IDX_LAST, 16'(st + 2));
      apb(1'b1, IDX_LAYOUT, {8'h02, 4'(last_word_output_count), code[k]});
      apb(1'b1, IDX_DIV_HI, 16'h0000);
      apb(1'b1, IDX_DIV_LO, 16'h0001);
      apb(1'b1, IDX_LOAD_PTR, 16'(st + 1));
      build(wid[k], last_word_output_count);
      apb(1'b1, IDX_CTRL, CTRL_START_VALUE);
      i = 0;
      while (chan_oe === 16'h0000 && i < 200) begin
         @(posedge pclk);
         i++;
      end
      repeat (12) @(posedge pclk);
      for (i = 0; i <= exp_q.size(); i++) begin
         cmp(exp_q[i % exp_q.size()]);
         repeat (24) @(posedge pclk);
      end
      do_reset();
   endtask : run

   // Closing report
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   // Main sequence
   initial begin
      void'($urandom(32'hED4A8205));
      do_reset();
      foreach (regs[i]) begin
         rchk(regs[i], 16'h0000);
      end
      apb(1'b0, 6'h01, 16'h0000);
      `CHK({err, rd}, {1'b1, 32'h0000_0000})
      apb(1'b1, 6'h02, 16'hFFFF);
      `CHK(err, 1'b1)
      for (int i = 0; i < 4; i++) begin
         v = 16'($urandom);
         apb(1'b1, IDX_DIV_HI, v);
         rchk(IDX_DIV_HI, v);
      end
      for (int k = 0; k < 5; k++) begin
         run(k);
      end
      results();
   end
endmodule : pwg_pattern_generator_test
